/* common/oss_consts.vh */
// Constants for the output synchronisation supervisor: offsets, fields, resets, timing.
// Assumes inclusion by bare name from core/oss_supervisor.v.
`ifndef OSS_CONSTS_VH
`define OSS_CONSTS_VH

// ********************************************************************
// Register indices (byte address = 4 * index)
// ********************************************************************
`define OSS_IDX_ENTRY_COUNT   8'h00
`define OSS_IDX_MODE          8'h01
`define OSS_IDX_CYCLE         8'h02
`define OSS_IDX_SHIFT         8'h03
`define OSS_IDX_SUPPORTED     8'h04
`define OSS_IDX_MIN_PERIOD    8'h05
`define OSS_IDX_CALC_COPY     8'h06
`define OSS_IDX_MIN_DELAY     8'h07
`define OSS_IDX_COMMAND       8'h08
`define OSS_IDX_MAX_DELAY     8'h09
`define OSS_IDX_MISSED        8'h0B
`define OSS_IDX_OVERRUN       8'h0C
`define OSS_IDX_SHORT_SHIFT   8'h0D
`define OSS_IDX_LATE_FLAG     8'h20
`define OSS_IDX_IRQ_STATUS    8'h30
`define OSS_IDX_IRQ_MASK      8'h31
`define OSS_IDX_OPERATIONAL   8'h32

// ********************************************************************
// Reset and constant values
// ********************************************************************
`define OSS_ENTRY_COUNT_VAL   8'h20
`define OSS_MODE_RST          16'h0001
`define OSS_CYCLE_RST         32'h000F4240
`define OSS_SUPPORTED_VAL     16'h0807
`define OSS_MIN_PERIOD_VAL    32'h000101D0
`define OSS_CMD_STOP          16'h0000
`define OSS_CMD_START         16'h0001

// ********************************************************************
// Mode codes and supported-mode fields
// ********************************************************************
`define OSS_MODE_FREE         16'h0000
`define OSS_MODE_SM           16'h0001
`define OSS_MODE_DC0          16'h0002
`define OSS_MODE_DC1          16'h0003
`define OSS_SUP_FREE_BIT      0
`define OSS_SUP_SM_BIT        1
`define OSS_SUP_DC_LSB        2
`define OSS_SUP_SHIFT_LSB     4
`define OSS_SUP_DYN_BIT       14

// ********************************************************************
// Interrupt status bits
// ********************************************************************
`define OSS_IRQ_MISSED        0
`define OSS_IRQ_OVERRUN       1
`define OSS_IRQ_SHORT         2
`define OSS_IRQ_LATE          3
`define OSS_IRQ_W             4

// ********************************************************************
// Timing
// ********************************************************************
`define OSS_CLK_PERIOD_NS     50
`define OSS_NS_PER_TICK       32'h00000032

`endif

/* core/oss_supervisor.v */
// Output synchronisation supervisor: mode, cycle timing, measurement, error counters.
// Assumes one 20 MHz clock; event inputs are pulses synchronous to i_clk.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "oss_consts.vh"

module oss_supervisor (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // Register port
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    // Synchronisation events from the fieldbus side
    input  wire        i_sm_event,
    input  wire        i_sync0,
    input  wire        i_sync1,
    // Output update done by the process logic
    input  wire        i_output_done,
    // Output update strobe and interrupt
    output reg         o_output_update,
    output wire        o_irq
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [15:0] mode;              // Selected synchronisation mode
    reg  [31:0] cycle_ns;          // Cycle period in ns
    reg  [15:0] command;           // Measurement command word
    reg         operational;       // Operational state flag from software
    reg  [31:0] shift_ns;          // Measured shift maximum
    reg  [31:0] calc_copy_ns;      // Measured SYNC0-SYNC1 maximum
    reg  [31:0] min_delay_ns;      // Reported minimum SYNC1-output delay
    reg  [31:0] max_delay_ns;      // Measured SYNC1-output maximum
    reg  [31:0] min_period_ns;     // Reported minimum cycle
    reg  [15:0] missed_cnt;        // Missed SM events
    reg  [15:0] overrun_cnt;       // Overrun cycles
    reg  [15:0] short_cnt;         // Too short SYNC0-SYNC1
    reg         late_flag;         // Outputs late in last cycle
    reg  [`OSS_IRQ_W-1:0] irq_status; // Sticky events
    reg  [`OSS_IRQ_W-1:0] irq_mask;   // Interrupt enables
    reg  [31:0] timer_ns;          // Time since local timer wrap
    reg  [31:0] since_sync0_ns;    // Time since SYNC0
    reg  [31:0] since_sync1_ns;    // Time since SYNC1
    reg         cycle_busy;        // Cycle started, output pending
    reg         sm_seen;           // SM event seen this DC cycle
    reg         sync1_pending;     // SYNC1 seen, output pending

    wire dc_mode  = (mode == `OSS_MODE_DC0) || (mode == `OSS_MODE_DC1);
    wire measuring = (command == `OSS_CMD_START);
    wire start_cmd = i_wr && (i_addr == `OSS_IDX_COMMAND)
                     && (i_wdata[15:0] == `OSS_CMD_START) && !measuring;

    // Local timer wrap defines the free-run cycle start
    wire timer_wrap = (timer_ns + `OSS_NS_PER_TICK) >= cycle_ns;

    // Cycle start by the selected source
    reg cycle_start;
    always @* begin
        case (mode)
            `OSS_MODE_FREE: cycle_start = timer_wrap;
            `OSS_MODE_SM:   cycle_start = i_sm_event;
            `OSS_MODE_DC0:  cycle_start = i_sync0;
            `OSS_MODE_DC1:  cycle_start = i_sync1;
            default:        cycle_start = 1'b0;
        endcase
    end

    // Events of this cycle
    wire ev_overrun = operational && cycle_start && cycle_busy;
    wire ev_missed  = operational && dc_mode && i_sync0 && !sm_seen;
    wire ev_short   = dc_mode && i_sync1 && (since_sync0_ns < calc_copy_ns);
    wire ev_late    = dc_mode && i_output_done && (since_sync0_ns > cycle_ns);
    wire [`OSS_IRQ_W-1:0] ev_vec = {ev_late, ev_short, ev_overrun, ev_missed};

    // Saturating increment
    function [15:0] sat_inc;
        input [15:0] v;
        begin
            sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
        end
    endfunction

    // ****************************************************************
    // Timers and cycle tracking
    // ****************************************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_ns        <= 32'h00000000;
            since_sync0_ns  <= 32'h00000000;
            since_sync1_ns  <= 32'h00000000;
            cycle_busy      <= 1'b0;
            sm_seen         <= 1'b0;
            sync1_pending   <= 1'b0;
            o_output_update <= 1'b0;
        end else begin
            // SYNC0 and SYNC1 interval timers stop only at 32'hFFFFFFFF, which 50 ns steps from zero never reach, so stale intervals wrap to small values
            timer_ns <= timer_wrap ? 32'h00000000 : timer_ns + `OSS_NS_PER_TICK;
            if (i_sync0)
                since_sync0_ns <= 32'h00000000;
            else if (since_sync0_ns != 32'hFFFFFFFF)
                since_sync0_ns <= since_sync0_ns + `OSS_NS_PER_TICK;
            if (i_sync1)
                since_sync1_ns <= 32'h00000000;
            else if (since_sync1_ns != 32'hFFFFFFFF)
                since_sync1_ns <= since_sync1_ns + `OSS_NS_PER_TICK;
            // Output strobe follows every cycle start
            o_output_update <= cycle_start;
            if (cycle_start)
                cycle_busy <= 1'b1;
            else if (i_output_done)
                cycle_busy <= 1'b0;
            // SM event expected once between SYNC0 events
            if (i_sync0)
                sm_seen <= i_sm_event;
            else if (i_sm_event)
                sm_seen <= 1'b1;
            if (i_sync1)
                sync1_pending <= 1'b1;
            else if (i_output_done)
                sync1_pending <= 1'b0;
        end
    end

    // ****************************************************************
    // Measurement and counters
    // ****************************************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_ns      <= 32'h00000000;
            calc_copy_ns  <= 32'h00000000;
            min_delay_ns  <= 32'h00000000;
            max_delay_ns  <= 32'h00000000;
            min_period_ns <= `OSS_MIN_PERIOD_VAL;
            missed_cnt    <= 16'h0000;
            overrun_cnt   <= 16'h0000;
            short_cnt     <= 16'h0000;
            late_flag     <= 1'b0;
        end else begin
            if (start_cmd) begin
                // Fresh measurement forgets old maxima
                shift_ns      <= 32'h00000000;
                calc_copy_ns  <= 32'h00000000;
                max_delay_ns  <= 32'h00000000;
                min_period_ns <= 32'h00000000;
            end else if (measuring && i_output_done) begin
                if (dc_mode && since_sync0_ns > shift_ns)
                    shift_ns <= since_sync0_ns;
                if (dc_mode && sync1_pending && since_sync1_ns > max_delay_ns)
                    max_delay_ns <= since_sync1_ns;
                if (timer_ns > min_period_ns && mode == `OSS_MODE_FREE)
                    min_period_ns <= timer_ns;
            end
            if (measuring && dc_mode && i_sync1 && since_sync0_ns > calc_copy_ns)
                calc_copy_ns <= since_sync0_ns;
            // Smallest delay seen from SYNC1 to output
            if (dc_mode && sync1_pending && i_output_done
                && (min_delay_ns == 32'h00000000 || since_sync1_ns < min_delay_ns))
                min_delay_ns <= since_sync1_ns;
            if (ev_missed)
                missed_cnt <= sat_inc(missed_cnt);
            if (ev_overrun)
                overrun_cnt <= sat_inc(overrun_cnt);
            if (ev_short)
                short_cnt <= sat_inc(short_cnt);
            if (dc_mode && i_output_done)
                late_flag <= ev_late;
        end
    end

    // ****************************************************************
    // Register writes and interrupt status
    // ****************************************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode        <= `OSS_MODE_RST;
            cycle_ns    <= `OSS_CYCLE_RST;
            command     <= `OSS_CMD_STOP;
            operational <= 1'b0;
            irq_mask    <= {`OSS_IRQ_W{1'b0}};
            irq_status  <= {`OSS_IRQ_W{1'b0}};
        end else begin
            if (i_wr) begin
                case (i_addr)
                    `OSS_IDX_MODE:        mode <= i_wdata[15:0];
                    `OSS_IDX_CYCLE:       cycle_ns <= i_wdata;
                    `OSS_IDX_COMMAND:     command <= i_wdata[15:0];
                    `OSS_IDX_OPERATIONAL: operational <= i_wdata[0];
                    `OSS_IDX_IRQ_MASK:    irq_mask <= i_wdata[`OSS_IRQ_W-1:0];
                    default: ;
                endcase
            end
            // Set wins over a simultaneous write-one clear
            if (i_wr && i_addr == `OSS_IDX_IRQ_STATUS)
                irq_status <= (irq_status & ~i_wdata[`OSS_IRQ_W-1:0]) | ev_vec;
            else
                irq_status <= irq_status | ev_vec;
        end
    end

    assign o_irq = |(irq_status & irq_mask);

    // ****************************************************************
    // Register reads, one cycle latency
    // ****************************************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `OSS_IDX_ENTRY_COUNT: o_rdata <= {24'h000000, `OSS_ENTRY_COUNT_VAL};
                `OSS_IDX_MODE:        o_rdata <= {16'h0000, mode};
                `OSS_IDX_CYCLE:       o_rdata <= cycle_ns;
                `OSS_IDX_SHIFT:       o_rdata <= shift_ns;
                `OSS_IDX_SUPPORTED:   o_rdata <= {16'h0000, `OSS_SUPPORTED_VAL};
                `OSS_IDX_MIN_PERIOD:  o_rdata <= min_period_ns;
                `OSS_IDX_CALC_COPY:   o_rdata <= calc_copy_ns;
                `OSS_IDX_MIN_DELAY:   o_rdata <= min_delay_ns;
                `OSS_IDX_COMMAND:     o_rdata <= {16'h0000, command};
                `OSS_IDX_MAX_DELAY:   o_rdata <= max_delay_ns;
                `OSS_IDX_MISSED:      o_rdata <= {16'h0000, missed_cnt};
                `OSS_IDX_OVERRUN:     o_rdata <= {16'h0000, overrun_cnt};
                `OSS_IDX_SHORT_SHIFT: o_rdata <= {16'h0000, short_cnt};
                `OSS_IDX_LATE_FLAG:   o_rdata <= {31'h00000000, late_flag};
                `OSS_IDX_IRQ_STATUS:  o_rdata <= {28'h0000000, irq_status};
                `OSS_IDX_IRQ_MASK:    o_rdata <= {28'h0000000, irq_mask};
                `OSS_IDX_OPERATIONAL: o_rdata <= {31'h00000000, operational};
                default:              o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

endmodule // oss_supervisor
`default_nettype wire

/* tb/oss_master_model.sv */
// Fieldbus master model: SM event, SYNC0, SYNC1 and output-done pulses.
// Assumes the bench calls pulse() and runs nothing else at the same time.
`timescale 1ns/1ps
`default_nettype none
module oss_master_model (
    // Clock
    input  wire logic i_clk,
    // Event pulses, one cycle each
    output var  logic o_sm,
    output var  logic o_s0,
    output var  logic o_s1,
    output var  logic o_done
);
    // Lines idle low from time zero
    initial {o_sm, o_s0, o_s1, o_done} = 4'h0;
    // Pulse one line (0 SM, 1 SYNC0, 2 SYNC1, 3 done), then n idle cycles
    // Events are always at least two cycles apart, so a cycle never collapses
    task automatic pulse(input int sel, input int n);
        @(posedge i_clk);
        o_sm <= (sel == 0);
        o_s0 <= (sel == 1);
        o_s1 <= (sel == 2);
        o_done <= (sel == 3);
        @(posedge i_clk);
        {o_sm, o_s0, o_s1, o_done} <= 4'h0;
        repeat (n) @(posedge i_clk);
    endtask
endmodule // oss_master_model
`default_nettype wire

/* tb/oss_supervisor_assertions.sv */
// Assertion checker for the output sync supervisor, bound to its ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module oss_supervisor_assertions (
    // Clock, reset, register port
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    // Events and outputs
    input wire logic        i_sm_event,
    input wire logic        i_sync0,
    input wire logic        i_sync1,
    input wire logic        i_output_done,
    input wire logic        o_output_update,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Mode as last written; wide codes ignored so the tracker stays legal
    logic [1:0] mode_seen;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) mode_seen <= 2'h1;
        else if (i_wr && i_addr == 8'h01 && i_wdata[15:2] == 14'h0) mode_seen <= i_wdata[1:0];
    end
    a_entry_count_read: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == 32'h20)
        else $error("entry count read wrong");
    a_supported_word: assert property (i_rd && i_addr == 8'h04 |=> o_rdata == 32'h0807)
        else $error("supported modes word wrong");
    a_dc_support_bits: assert property (i_rd && i_addr == 8'h04 |=> o_rdata[3:0] == 4'h7)
        else $error("supported mode bits wrong");
    a_unmapped_zero: assert property (i_rd && i_addr > 8'h32 |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_sm_update: assert property (mode_seen == 2'h1 && i_sm_event |=> o_output_update)
        else $error("no update after SM event");
    a_sync0_update: assert property (mode_seen == 2'h2 && i_sync0 |=> o_output_update)
        else $error("no update after SYNC0");
    a_sync1_update: assert property (mode_seen == 2'h3 && i_sync1 |=> o_output_update)
        else $error("no update after SYNC1");
    a_sm_cause: assert property (mode_seen == 2'h1 && o_output_update |-> $past(i_sm_event))
        else $error("update without SM event");
    c_sm_cycle: cover property (mode_seen == 2'h1 && i_sm_event ##1 o_output_update);
    c_sync1_cycle: cover property (mode_seen == 2'h3 && i_sync1 ##1 o_output_update);
    c_irq: cover property ($rose(o_irq));
endmodule // oss_supervisor_assertions
bind oss_supervisor oss_supervisor_assertions u_sva (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_sm_event(i_sm_event), .i_sync0(i_sync0),
    .i_sync1(i_sync1), .i_output_done(i_output_done), .o_output_update(o_output_update),
    .o_irq(o_irq));
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the output sync supervisor.
// Assumes the master model drives all events; registers via the plain port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        i_clk, i_rst_n, i_wr, i_rd;       // Clock, reset, strobes
    logic [7:0]  i_addr;                           // Register index
    logic [31:0] i_wdata, o_rdata, va, vb;         // Bus data and saved reads
    logic        o_output_update, o_irq, sm, s0, s1, dn; // Outputs, events
    int          n_errors, cmp_count;              // Verdict counters
    logic [7:0]  zidx [9] = '{8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h20};
    oss_supervisor uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sm_event(sm), .i_sync0(s0),
        .i_sync1(s1), .i_output_done(dn), .o_output_update(o_output_update), .o_irq(o_irq));
    oss_master_model fb (.i_clk(i_clk), .o_sm(sm), .o_s0(s0), .o_s1(s1), .o_done(dn));
    // 20 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Single-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
        rd(a, va);
        chk(what, e, va);
    endtask
    task automatic dc_cycle(input int n);
        fb.pulse(1, 0);
        fb.pulse(2, n);
        fb.pulse(3, 0);
    endtask
    task automatic t_reset_vals();
        rdc("entries", 8'h00, 32'h20);
        rdc("mode", 8'h01, 32'h1);
        rdc("cycle", 8'h02, 32'h000F4240);
        rdc("modes_sup", 8'h04, 32'h0807);
        rdc("min_cycle", 8'h05, 32'h000101D0);
        foreach (zidx[i]) rdc("zero_reg", zidx[i], 32'h0);
        wr(8'h04, 32'h0);
        rdc("modes_sup_ro", 8'h04, 32'h0807);
        rdc("unmapped", 8'hFF, 32'h0);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(8'h01, 32'(m));
            rdc("mode_rw", 8'h01, 32'(m));
        end
        wr(8'h01, 32'h1);
        fb.pulse(0, 0);
        #1 chk("update", 32'h1, {31'h0, o_output_update});
        fb.pulse(3, 2);
    endtask
    // Missed SM event raises status; mask gates the interrupt; W1C clears
    task automatic t_missed_irq();
        wr(8'h32, 32'h1);
        wr(8'h01, 32'h2);
        fb.pulse(0, 0);
        dc_cycle(0);
        dc_cycle(0);
        rdc("missed", 8'h0B, 32'h1);
        #1 chk("irq_masked", 32'h0, {31'h0, o_irq});
        wr(8'h31, 32'h1);
        #1 chk("irq_on", 32'h1, {31'h0, o_irq});
        wr(8'h30, 32'h1);
        #1 chk("irq_off", 32'h0, {31'h0, o_irq});
        rdc("overrun0", 8'h0C, 32'h0);
    endtask
    task automatic t_overrun();
        wr(8'h01, 32'h1);
        fb.pulse(0, 0);
        fb.pulse(0, 0);
        fb.pulse(3, 0);
        rdc("overrun", 8'h0C, 32'h1);
        rdc("missed_sm", 8'h0B, 32'h1);
    endtask
    task automatic t_late();
        wr(8'h01, 32'h2);
        wr(8'h02, 32'h1F4);
        rdc("cycle_rw", 8'h02, 32'h1F4);
        fb.pulse(1, 20);
        fb.pulse(3, 0);
        rdc("late", 8'h20, 32'h1);
        fb.pulse(1, 0);
        fb.pulse(3, 0);
        rdc("in_time", 8'h20, 32'h0);
    endtask
    // Relative reads: a four-tick longer delay must add exactly 200 ns
    task automatic t_measure();
        wr(8'h01, 32'h3);
        wr(8'h08, 32'h1);
        rdc("command", 8'h08, 32'h1);
        dc_cycle(2);
        rd(8'h09, va);
        dc_cycle(6);
        rd(8'h09, vb);
        chk("max_delay_step", 32'hC8, vb - va);
        dc_cycle(2);
        rdc("max_delay_kept", 8'h09, vb);
        rd(8'h09, vb);
        wr(8'h08, 32'h0);
        wr(8'h08, 32'h1);
        dc_cycle(2);
        rd(8'h09, va);
        chk("max_delay_new", vb - 32'hC8, va);
        rdc("shift_max", 8'h03, 32'hFA);
        rdc("calc_copy", 8'h06, 32'h32);
        rdc("min_delay", 8'h07, 32'h32);
        rdc("short0", 8'h0D, 32'h0);
        // Widen the required gap, then a tight cycle must count as too short
        fb.pulse(1, 4);
        fb.pulse(2, 0);
        fb.pulse(3, 0);
        dc_cycle(0);
        rdc("short1", 8'h0D, 32'h1);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {i_wr, i_rd, i_rst_n} = 3'h0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        n_errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset_vals();
        t_modes();
        t_missed_irq();
        t_overrun();
        t_late();
        t_measure();
        finish_test();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        finish_test();
    end
endmodule // testbench
`default_nettype wire
